/* File: rtl/smbt_timing.v */
// Purpose: bus timing generation and timeout supervision for a two-wire bus
// Assumes: 20 MHz clk; bus pins open drain, oe high pulls line low
// Notes:   controller side generates clock; target side watches stretches
// Notes on behaviour
// - speed class selects bus free, START setup and hold, STOP setup, clock max and spike filter
// - generated clock between 10 kHz and max
// - detect START at fastest class timing
// - target releases lines after 25 ms low
// - after timeout, ready within 35 ms
// - controller issues STOP after timeout
// - forced timeout holds clock at least 35 ms
// - bus free after 50 us high; high capped
// - bus free time before START
// - start hold before first clock
// - setup before repeated START and STOP
// - target total stretch per message 25 ms
// - controller stretch per byte 10 ms
// - periodic stretch keeps rate above minimum
// - reject 50 ns input glitches in 400 kHz and 1 MHz classes
// - operational within 500 ms of reset
// - simple device restarts on START or STOP
`timescale 1ns/100ps
`include "smbt_consts.vh"
module smbt_timing #(
  parameter [1:0] SPEED_CLASS = `SMBT_CLASS_100K,  // build-time class
  parameter TIMEOUT_MIN_CYC = `SMBT_CYC_MS(`SMBT_TIMEOUT_MIN_MS),
  parameter TIMEOUT_MAX_CYC = `SMBT_CYC_MS(`SMBT_TIMEOUT_MAX_MS),
  parameter TEXT_CYC        = `SMBT_CYC_MS(`SMBT_TEXT_MS),
  parameter CEXT_CYC        = `SMBT_CYC_MS(`SMBT_CEXT_MS),
  parameter POR_CYC         = `SMBT_CYC_MS(`SMBT_POR_MS),
  parameter HIGH_MAX_CYC    = `SMBT_CYC_US(`SMBT_HIGH_MAX_US),
  parameter CNT_W           = 24      // wide enough for POR_CYC
) (
  input  wire clk,
  input  wire rst,
  input  wire clk_pin_in,             // bus clock line level
  input  wire dat_pin_in,             // bus data line level
  output reg  clk_pin_oe,             // pull bus clock low
  output reg  dat_pin_oe,             // pull bus data low
  input  wire start_req,              // pulse: controller wants START / repeated START
  input  wire stop_req,               // pulse: controller wants STOP
  input  wire bit_req,                // pulse: generate one clock bit
  input  wire bit_val,                // data value for that bit
  input  wire ack_mark,               // pulse: byte boundary (ACK) seen by link logic
  input  wire tgt_stretch,            // level: target logic wants clock held low
  input  wire force_timeout,          // pulse: deliberately hold clock for timeout
  output reg  ready_reg,              // device operational after power-on
  output reg  busy_reg,               // controller sequence in progress
  output reg  bus_free_reg,           // bus seen idle
  output reg  start_seen_reg,         // pulse: START detected
  output reg  stop_seen_reg,          // pulse: STOP detected
  output reg  timeout_reg,            // pulse: clock-low timeout detected
  output reg  comm_reset_reg,         // pulse: reset the communication logic
  output reg  text_viol_reg,          // level: target stretch budget spent
  output reg  cext_viol_reg           // level: controller stretch budget spent
);
  // per class intervals, least times rounded up
  localparam BUF_C = (SPEED_CLASS == `SMBT_CLASS_1M) ? `SMBT_CYC_NS(`SMBT_BUF_1M_NS) :
    (SPEED_CLASS == `SMBT_CLASS_400K) ? `SMBT_CYC_NS(`SMBT_BUF_400K_NS) :
    `SMBT_CYC_NS(`SMBT_BUF_100K_NS);
  localparam HDSTA_C = (SPEED_CLASS == `SMBT_CLASS_1M) ? `SMBT_CYC_NS(`SMBT_HDSTA_1M_NS) :
    (SPEED_CLASS == `SMBT_CLASS_400K) ? `SMBT_CYC_NS(`SMBT_HDSTA_400K_NS) :
    `SMBT_CYC_NS(`SMBT_HDSTA_100K_NS);
  localparam SUSTA_C = (SPEED_CLASS == `SMBT_CLASS_1M) ? `SMBT_CYC_NS(`SMBT_SUSTA_1M_NS) :
    (SPEED_CLASS == `SMBT_CLASS_400K) ? `SMBT_CYC_NS(`SMBT_SUSTA_400K_NS) :
    `SMBT_CYC_NS(`SMBT_SUSTA_100K_NS);
  localparam SUSTO_C = (SPEED_CLASS == `SMBT_CLASS_1M) ? `SMBT_CYC_NS(`SMBT_SUSTO_1M_NS) :
    (SPEED_CLASS == `SMBT_CLASS_400K) ? `SMBT_CYC_NS(`SMBT_SUSTO_400K_NS) :
    `SMBT_CYC_NS(`SMBT_SUSTO_100K_NS);
  localparam FMAX_K = (SPEED_CLASS == `SMBT_CLASS_1M) ? `SMBT_FREQ_MAX_1M :
    (SPEED_CLASS == `SMBT_CLASS_400K) ? `SMBT_FREQ_MAX_400K : `SMBT_FREQ_MAX_100K;
  // half period rounded up: rate never above class max
  localparam HALF_C = (`SMBT_CLK_KHZ + 2 * FMAX_K - 1) / (2 * FMAX_K);
  // slowest permitted period, rounded down
  localparam PER_MAX_C = `SMBT_CLK_KHZ / `SMBT_FREQ_MIN_KHZ;
  localparam SPIKE_ON = (SPEED_CLASS != `SMBT_CLASS_100K);

  // controller states
  localparam ST_IDLE  = 3'h0;         // waiting for a request
  localparam ST_BUF   = 3'h1;         // bus free wait before START
  localparam ST_SUSTA = 3'h2;         // clock high before repeated START
  localparam ST_HDSTA = 3'h3;         // data low, clock high after START
  localparam ST_LOW   = 3'h4;         // clock low half
  localparam ST_HIGH  = 3'h5;         // clock high half
  localparam ST_SUSTO = 3'h6;         // clock high, data low before STOP
  localparam ST_FORCE = 3'h7;         // deliberate clock-low hold

  wire scl;                           // filtered clock line
  wire sda;                           // filtered data line
  reg  scl_d_reg;                     // previous filtered clock
  reg  sda_d_reg;                     // previous filtered data
  reg  [CNT_W-1:0] low_cnt_reg;       // single clock-low interval
  reg  [CNT_W-1:0] high_cnt_reg;      // time both lines high
  reg  [CNT_W-1:0] por_cnt_reg;       // power-on readiness
  reg  [CNT_W-1:0] text_cnt_reg;      // target stretch in message
  reg  [CNT_W-1:0] cext_cnt_reg;      // controller stretch in byte
  reg  [CNT_W-1:0] tmr_reg;           // controller phase timer
  reg  [CNT_W-1:0] rec_cnt_reg;       // recovery after timeout
  reg  [2:0]       state_reg;         // controller state
  reg              stop_pend_reg;     // STOP owed after timeout
  reg              in_msg_reg;        // between START and STOP
  reg              recover_reg;       // lines released after timeout
  reg              timed_out_reg;     // timeout already flagged this low

  // glitch filters on both bus inputs
  smbt_filter #(.FILT_LEN(`SMBT_SPIKE_CYC)) u_fclk (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (clk_pin_in),
    .bypass    (!SPIKE_ON),
    .level_reg (scl)
  );
  smbt_filter #(.FILT_LEN(`SMBT_SPIKE_CYC)) u_fdat (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (dat_pin_in),
    .bypass    (!SPIKE_ON),
    .level_reg (sda)
  );

  // bus monitor: conditions, low timeout, idle detect, budgets
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d_reg      <= 1'b1;
      sda_d_reg      <= 1'b1;
      low_cnt_reg    <= {CNT_W{1'b0}};
      high_cnt_reg   <= {CNT_W{1'b0}};
      por_cnt_reg    <= {CNT_W{1'b0}};
      text_cnt_reg   <= {CNT_W{1'b0}};
      cext_cnt_reg   <= {CNT_W{1'b0}};
      rec_cnt_reg    <= {CNT_W{1'b0}};
      ready_reg      <= 1'b0;
      bus_free_reg   <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
      timeout_reg    <= 1'b0;
      comm_reset_reg <= 1'b0;
      text_viol_reg  <= 1'b0;
      cext_viol_reg  <= 1'b0;
      in_msg_reg     <= 1'b0;
      recover_reg    <= 1'b0;
      timed_out_reg  <= 1'b0;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      // readiness reached right at the power-on limit
      if (por_cnt_reg < POR_CYC[CNT_W-1:0] - 1'b1) begin
        por_cnt_reg <= por_cnt_reg + 1'b1;
      end else begin
        ready_reg <= 1'b1;
      end
      // data edge while clock high
      start_seen_reg <= scl && scl_d_reg && sda_d_reg && !sda;
      stop_seen_reg  <= scl && scl_d_reg && !sda_d_reg && sda;
      // restart on START or STOP, or at timeout
      comm_reset_reg <= (scl && scl_d_reg && (sda_d_reg != sda)) ||
                        (low_cnt_reg == TIMEOUT_MIN_CYC[CNT_W-1:0]);
      if (scl && scl_d_reg && sda_d_reg && !sda) begin
        in_msg_reg    <= 1'b1;
        text_cnt_reg  <= {CNT_W{1'b0}};
        cext_cnt_reg  <= {CNT_W{1'b0}};
        text_viol_reg <= 1'b0;
        cext_viol_reg <= 1'b0;
      end else if (scl && scl_d_reg && !sda_d_reg && sda) begin
        in_msg_reg <= 1'b0;
      end
      // low counter restarts on fall, clears on return high
      if (scl_d_reg && !scl) begin
        low_cnt_reg   <= {CNT_W{1'b0}};
        timed_out_reg <= 1'b0;
      end else if (scl) begin
        low_cnt_reg   <= {CNT_W{1'b0}};
        timed_out_reg <= 1'b0;
      end else if (low_cnt_reg != {CNT_W{1'b1}}) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
      end
      // timeout after a single low interval of the minimum length
      timeout_reg <= 1'b0;
      if (!scl && !timed_out_reg && low_cnt_reg >= TIMEOUT_MIN_CYC[CNT_W-1:0]) begin
        timeout_reg   <= 1'b1;
        timed_out_reg <= 1'b1;
        recover_reg   <= 1'b1;
        rec_cnt_reg   <= {CNT_W{1'b0}};
        in_msg_reg    <= 1'b0;
      end else if (recover_reg) begin
        // released until clock rises or max passes
        rec_cnt_reg <= rec_cnt_reg + 1'b1;
        if (scl || rec_cnt_reg >= TIMEOUT_MAX_CYC[CNT_W-1:0] - TIMEOUT_MIN_CYC[CNT_W-1:0]) begin
          recover_reg <= 1'b0;
        end
      end
      // idle once both lines high past the high limit
      if (scl && sda) begin
        if (high_cnt_reg <= HIGH_MAX_CYC[CNT_W-1:0]) begin
          high_cnt_reg <= high_cnt_reg + 1'b1;
        end
      end else begin
        high_cnt_reg <= {CNT_W{1'b0}};
      end
      bus_free_reg <= scl && sda && (high_cnt_reg > HIGH_MAX_CYC[CNT_W-1:0]);
      // target stretch budget over whole message
      if (in_msg_reg && tgt_stretch && !scl) begin
        text_cnt_reg <= text_cnt_reg + 1'b1;
        if (text_cnt_reg >= TEXT_CYC[CNT_W-1:0] - 1'b1) begin
          text_viol_reg <= 1'b1;
        end
      end
      // controller stretch budget per byte, reset at each ACK
      if (ack_mark) begin
        cext_cnt_reg <= {CNT_W{1'b0}};
      end else if (busy_reg && state_reg == ST_LOW && tmr_reg >= HALF_C[CNT_W-1:0]) begin
        cext_cnt_reg <= cext_cnt_reg + 1'b1;
        if (cext_cnt_reg >= CEXT_CYC[CNT_W-1:0] - 1'b1) begin
          cext_viol_reg <= 1'b1;
        end
      end
    end
  end

  // controller sequencer and pin drivers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      tmr_reg       <= {CNT_W{1'b0}};
      clk_pin_oe    <= 1'b0;
      dat_pin_oe    <= 1'b0;
      busy_reg      <= 1'b0;
      stop_pend_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_reg + 1'b1;
      if (timeout_reg && busy_reg) begin
        stop_pend_reg <= 1'b1;        // STOP owed after current bit
      end
      case (state_reg)
        ST_IDLE: begin
          busy_reg <= 1'b0;
          // target stretch holds clock; dropped while recovering
          clk_pin_oe <= tgt_stretch && !recover_reg && !text_viol_reg;
          dat_pin_oe <= 1'b0;
          tmr_reg    <= {CNT_W{1'b0}};
          stop_pend_reg <= 1'b0;     // no STOP owed from an old sequence
          if (!ready_reg) begin
            state_reg <= ST_IDLE;
          end else if (force_timeout) begin
            state_reg  <= ST_FORCE;
            busy_reg   <= 1'b1;
          end else if (start_req && !recover_reg) begin
            state_reg <= ST_BUF;
            busy_reg  <= 1'b1;
          end
        end
        ST_BUF: begin
          // wait bus free time, restart if the bus is not high
          if (!(scl && sda)) begin
            tmr_reg <= {CNT_W{1'b0}};
          end else if (tmr_reg >= BUF_C[CNT_W-1:0]) begin
            dat_pin_oe <= 1'b1;
            tmr_reg    <= {CNT_W{1'b0}};
            state_reg  <= ST_HDSTA;
          end
        end
        ST_SUSTA: begin
          // clock high with data released before repeated START
          clk_pin_oe <= 1'b0;
          dat_pin_oe <= 1'b0;
          if (!scl) begin
            tmr_reg <= {CNT_W{1'b0}};
          end else if (tmr_reg >= SUSTA_C[CNT_W-1:0]) begin
            dat_pin_oe <= 1'b1;
            tmr_reg    <= {CNT_W{1'b0}};
            state_reg  <= ST_HDSTA;
          end
        end
        ST_HDSTA: begin
          // hold start before first clock
          if (tmr_reg >= HDSTA_C[CNT_W-1:0]) begin
            clk_pin_oe <= 1'b1;
            tmr_reg    <= {CNT_W{1'b0}};
            state_reg  <= ST_LOW;
          end
        end
        ST_LOW: begin
          clk_pin_oe <= 1'b1;
          if (tmr_reg >= HALF_C[CNT_W-1:0] - 1'b1) begin
            if (stop_pend_reg || stop_req) begin
              dat_pin_oe <= 1'b1;
              if (tmr_reg >= (HALF_C[CNT_W-1:0] << 1)) begin
                clk_pin_oe    <= 1'b0;
                tmr_reg       <= {CNT_W{1'b0}};
                stop_pend_reg <= 1'b0;
                state_reg     <= ST_SUSTO;
              end
            end else if (start_req) begin
              dat_pin_oe <= 1'b0;
              clk_pin_oe <= 1'b0;
              tmr_reg    <= {CNT_W{1'b0}};
              state_reg  <= ST_SUSTA;
            end else if (bit_req && dat_pin_oe == bit_val) begin
              dat_pin_oe <= !bit_val; // data settles before clock rises
            end else if (bit_req) begin
              // period stays under the 10 kHz floor
              dat_pin_oe <= !bit_val;
              clk_pin_oe <= 1'b0;
              tmr_reg    <= {CNT_W{1'b0}};
              state_reg  <= ST_HIGH;
            end else if (tmr_reg >= PER_MAX_C[CNT_W-1:0] - HALF_C[CNT_W-1:0]) begin
              stop_pend_reg <= 1'b1;  // no bit in time: STOP
            end
          end
        end
        ST_HIGH: begin
          clk_pin_oe <= 1'b0;
          if (!scl) begin
            tmr_reg <= {CNT_W{1'b0}}; // stretched by another party
          end else if (tmr_reg >= HALF_C[CNT_W-1:0] - 1'b1) begin
            // high phase far below the idle-detect limit
            clk_pin_oe <= 1'b1;
            tmr_reg    <= {CNT_W{1'b0}};
            state_reg  <= ST_LOW;
          end
        end
        ST_SUSTO: begin
          // setup before releasing data for STOP
          if (!scl) begin
            tmr_reg <= {CNT_W{1'b0}};
          end else if (tmr_reg >= SUSTO_C[CNT_W-1:0]) begin
            dat_pin_oe <= 1'b0;
            tmr_reg    <= {CNT_W{1'b0}};
            state_reg  <= ST_IDLE;
          end
        end
        ST_FORCE: begin
          // hold clock past the max timeout so all parties time out
          clk_pin_oe <= 1'b1;
          dat_pin_oe <= 1'b0;
          if (tmr_reg >= TIMEOUT_MAX_CYC[CNT_W-1:0]) begin
            clk_pin_oe <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // smbt_timing

/* File: common/smbt_consts.vh */
// Purpose: shared timing constants for the bus timing and timeout block
// Assumes: 20 MHz system clock (50 ns period)
// Notes:   times kept in their own unit; cycle counts derived from them
`ifndef SMBT_CONSTS_VH
`define SMBT_CONSTS_VH

`define SMBT_CLK_KHZ          20000
// speed class encodings
`define SMBT_CLASS_100K       2'h0
`define SMBT_CLASS_400K       2'h1
`define SMBT_CLASS_1M         2'h2
// limits in their printed units
`define SMBT_FREQ_MIN_KHZ     10
`define SMBT_FREQ_MAX_100K    100
`define SMBT_FREQ_MAX_400K    400
`define SMBT_FREQ_MAX_1M      1000
`define SMBT_TIMEOUT_MIN_MS   25
`define SMBT_TIMEOUT_MAX_MS   35
`define SMBT_HIGH_MAX_US      50
`define SMBT_TEXT_MS          25
`define SMBT_CEXT_MS          10
`define SMBT_POR_MS           500
`define SMBT_STRETCH_EXEMPT_US 100
// bus free, start hold, start setup, stop setup in ns
`define SMBT_BUF_100K_NS      4700
`define SMBT_BUF_400K_NS      1300
`define SMBT_BUF_1M_NS        500
`define SMBT_HDSTA_100K_NS    4000
`define SMBT_HDSTA_400K_NS    600
`define SMBT_HDSTA_1M_NS      260
`define SMBT_SUSTA_100K_NS    4700
`define SMBT_SUSTA_400K_NS    600
`define SMBT_SUSTA_1M_NS      260
`define SMBT_SUSTO_100K_NS    4000
`define SMBT_SUSTO_400K_NS    600
`define SMBT_SUSTO_1M_NS      260
`define SMBT_SPIKE_NS         50
`define SMBT_CLK_NS           50
// derived cycle counts: least times round up
`define SMBT_CYC_NS(ns)       (((ns) + `SMBT_CLK_NS - 1) / `SMBT_CLK_NS)
`define SMBT_CYC_US(us)       ((us) * `SMBT_CLK_KHZ / 1000)
`define SMBT_CYC_MS(ms)       ((ms) * `SMBT_CLK_KHZ)
// spike filter length: spike width in cycles plus one
`define SMBT_SPIKE_CYC        (`SMBT_CYC_NS(`SMBT_SPIKE_NS) + 1)

`endif

/* File: rtl/smbt_filter.v */
// Purpose: synchronise and de-glitch one bus input
// Assumes: input is asynchronous to clk
// Notes:   two flops, then a level must hold FILT_LEN cycles
`timescale 1ns/100ps
module smbt_filter #(
  parameter FILT_LEN = 2              // cycles a new level must hold
) (
  input  wire clk,
  input  wire rst,
  input  wire pin_in,                 // raw pin level
  input  wire bypass,                 // no spike filtering (100 kHz class)
  output reg  level_reg               // clean level
);
  reg       sync1_reg;                // first synchroniser flop, read only by sync2
  reg       sync2_reg;                // second synchroniser flop
  reg [3:0] cnt_reg;                  // run length of a differing level

  // synchroniser and run-length filter; idle bus level is high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      cnt_reg   <= 4'h0;
      level_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      if (sync2_reg == level_reg) begin
        cnt_reg <= 4'h0;
      end else if (bypass || cnt_reg >= FILT_LEN[3:0] - 4'h1) begin
        level_reg <= sync2_reg;       // pulse outlived a spike
        cnt_reg   <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule // smbt_filter

/* File: verification/smbt_far.sv */
// Purpose: far-side party on the shared two-wire bus
// Assumes: pull-ups on both lines; link clock period 400 ns
// Notes:   clock idle outside frames; released lines float high
`timescale 1ns/100ps
module smbt_far (
  output reg far_clk_oe,  // high pulls the bus clock low
  output reg far_dat_oe   // high pulls the bus data low
);
  // both lines released at power-up
  initial begin
    far_clk_oe = 1'b0;
    far_dat_oe = 1'b0;
  end
  // fastest start, clock left low
  task do_start;
    begin
      far_dat_oe = 1'b1;
      #200 far_clk_oe = 1'b1;
    end
  endtask
  // stop: data low, clock up, data up
  task do_stop;
    begin
      far_dat_oe = 1'b1;
      #200 far_clk_oe = 1'b0;
      #200 far_dat_oe = 1'b0;
    end
  endtask
  // clock held low; a forced timeout holds past max
  task hold_low(input integer ns);
    begin
      far_clk_oe = 1'b1;
      #(ns) far_clk_oe = 1'b0;
    end
  endtask
endmodule // smbt_far

/* File: verification/smbt_chk.sv */
// Purpose: port-level timing checks for the bus timing block
// Assumes: 100 kHz class at 20 MHz; lines are wired-and
// Notes:   counters watch raw line levels, which lead the filtered view
`timescale 1ns/100ps
module smbt_chk #(
  parameter TIMEOUT_MIN_CYC = 200,   // shortened clock-low timeout
  parameter HIGH_MAX_CYC    = 40     // shortened idle detect
) (
  input wire clk,
  input wire rst,
  input wire clk_pin_in,
  input wire dat_pin_in,
  input wire clk_pin_oe,
  input wire dat_pin_oe,
  input wire ready_reg,
  input wire bus_free_reg,
  input wire timeout_reg,
  input wire comm_reset_reg
);
  localparam int BUF_CYC = 94;       // 4.7 us bus free / setup
  localparam int HD_CYC  = 80;       // 4.0 us: start hold and stop setup
  reg [15:0] low_cnt_reg;            // raw clock low run
  reg [15:0] hi_cnt_reg;             // raw both-lines-high run
  reg [15:0] chi_cnt_reg;            // raw clock high run
  reg [15:0] sta_cnt_reg;            // cycles since own start, saturating
  reg        dat_oe_reg;             // last data drive, for start edges
  // saturating run counters; start count begins full
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= 16'h0000;
      hi_cnt_reg  <= 16'h0000;
      chi_cnt_reg <= 16'h0000;
      sta_cnt_reg <= 16'hFFFF;
      dat_oe_reg  <= 1'b0;
    end else begin
      low_cnt_reg <= clk_pin_in ? 16'h0000 : low_cnt_reg + {15'h0000, ~&low_cnt_reg};
      chi_cnt_reg <= !clk_pin_in ? 16'h0000 : chi_cnt_reg + {15'h0000, ~&chi_cnt_reg};
      hi_cnt_reg  <= !(clk_pin_in && dat_pin_in) ? 16'h0000 :
                     hi_cnt_reg + {15'h0000, ~&hi_cnt_reg};
      sta_cnt_reg <= (dat_pin_oe && !dat_oe_reg && clk_pin_in) ? 16'h0000 :
                     sta_cnt_reg + {15'h0000, ~&sta_cnt_reg};
      dat_oe_reg  <= dat_pin_oe;
    end
  end
  early_drive_a: assert property (@(posedge clk) disable iff (rst)
    !ready_reg |-> !clk_pin_oe && !dat_pin_oe) else $error("bus driven before ready");
  ready_hold_a: assert property (@(posedge clk) disable iff (rst)
    ready_reg |=> ready_reg) else $error("ready dropped");
  timeout_len_a: assert property (@(posedge clk) disable iff (rst)
    timeout_reg |-> low_cnt_reg >= TIMEOUT_MIN_CYC) else $error("timeout too early");
  timeout_reset_a: assert property (@(posedge clk) disable iff (rst)
    timeout_reg |-> ##[0:2] comm_reset_reg) else $error("no reset after timeout");
  free_time_a: assert property (@(posedge clk) disable iff (rst)
    $rose(bus_free_reg) |-> hi_cnt_reg > HIGH_MAX_CYC) else $error("idle seen too soon");
  free_drop_a: assert property (@(posedge clk) disable iff (rst)
    $fell(clk_pin_in) |-> ##[0:8] !bus_free_reg) else $error("idle kept on activity");
  start_gap_a: assert property (@(posedge clk) disable iff (rst)
    $rose(dat_pin_oe) && clk_pin_in |-> hi_cnt_reg >= BUF_CYC) else $error("start gap short");
  start_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(clk_pin_oe) |-> sta_cnt_reg >= HD_CYC) else $error("start hold short");
  stop_setup_a: assert property (@(posedge clk) disable iff (rst)
    $fell(dat_pin_oe) && clk_pin_in |-> chi_cnt_reg >= HD_CYC) else $error("stop setup short");
endmodule // smbt_chk
bind smbt_timing smbt_chk #(.TIMEOUT_MIN_CYC(TIMEOUT_MIN_CYC), .HIGH_MAX_CYC(HIGH_MAX_CYC))
  i_smbt_chk (.clk(clk), .rst(rst), .clk_pin_in(clk_pin_in), .dat_pin_in(dat_pin_in),
  .clk_pin_oe(clk_pin_oe), .dat_pin_oe(dat_pin_oe), .ready_reg(ready_reg),
  .bus_free_reg(bus_free_reg), .timeout_reg(timeout_reg), .comm_reset_reg(comm_reset_reg));

/* File: verification/tb.sv */
// Purpose: self-checking bench for the bus timing block
// Assumes: 100 kHz class, shortened counts
// Notes:   inputs change by nba at rising edges, outputs read at falling edges
`timescale 1ns/100ps
`define CHK(a, e) chk_v((a), (e))
module tb;
  localparam TMIN = 200;  // shortened timeout bounds
  localparam TMAX = 280;
  localparam POR  = 20;
  localparam TEXT = 100;
  reg     clk, rst, start_req, stop_req, bit_req, bit_val, ack_mark, tgt_stretch, force_timeout;
  integer failures, samples_checked, n, m, k;
  reg     p, q;
  wire    clk_pin_oe, dat_pin_oe, far_clk_oe, far_dat_oe, ready_reg, busy_reg, bus_free_reg;
  wire    start_seen_reg, stop_seen_reg, timeout_reg, comm_reset_reg;
  wire    text_viol_reg, cext_viol_reg;
  // wired-and bus lines
  wire    scl = ~(clk_pin_oe | far_clk_oe);
  wire    sda = ~(dat_pin_oe | far_dat_oe);
  smbt_timing #(.TIMEOUT_MIN_CYC(TMIN), .TIMEOUT_MAX_CYC(TMAX), .TEXT_CYC(TEXT),
    .CEXT_CYC(60), .POR_CYC(POR), .HIGH_MAX_CYC(40)) i_smbt_timing (
    .clk(clk), .rst(rst), .clk_pin_in(scl), .dat_pin_in(sda), .clk_pin_oe(clk_pin_oe),
    .dat_pin_oe(dat_pin_oe), .start_req(start_req), .stop_req(stop_req), .bit_req(bit_req),
    .bit_val(bit_val), .ack_mark(ack_mark), .tgt_stretch(tgt_stretch),
    .force_timeout(force_timeout), .ready_reg(ready_reg), .busy_reg(busy_reg),
    .bus_free_reg(bus_free_reg), .start_seen_reg(start_seen_reg),
    .stop_seen_reg(stop_seen_reg), .timeout_reg(timeout_reg),
    .comm_reset_reg(comm_reset_reg), .text_viol_reg(text_viol_reg),
    .cext_viol_reg(cext_viol_reg));
  smbt_far i_smbt_far (.far_clk_oe(far_clk_oe), .far_dat_oe(far_dat_oe));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk_v(input [31:0] a, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (a !== e) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, a, e);
      end
    end
  endtask
  task summarize;
    begin
      if (failures == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // watched output; 6 = sequence ended
  function sel(input integer w);
    case (w)
      0: sel = start_seen_reg;
      1: sel = stop_seen_reg;
      2: sel = timeout_reg;
      4: sel = text_viol_reg;
      5: sel = busy_reg;
      default: sel = ~busy_reg;
    endcase
  endfunction
  // bounded wait; n = lim on timeout
  task wait_for(input integer w, input integer lim);
    begin
      n = 0;
      while (sel(w) !== 1'b1 && n < lim) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task ctrl_start(input v);
    begin
      @(posedge clk);
      bit_val <= v;
      bit_req <= 1'b1;
      start_req <= 1'b1;
      @(posedge clk);
      start_req <= 1'b0;
      wait_for(5, 5);
      `CHK(n < 5, 1);
    end
  endtask
  // stop held until seen, then wait for idle
  task ctrl_stop;
    begin
      @(posedge clk);
      stop_req <= 1'b1;
      bit_req <= 1'b0;
      wait_for(1, 4000);
      `CHK(n < 4000, 1);
      @(posedge clk);
      stop_req <= 1'b0;
      wait_for(6, 400);
      `CHK(n < 400, 1);
    end
  endtask
  // early start refused; ready after power-on count
  task t_por;
    begin
      start_req <= 1'b1;
      @(posedge clk);
      start_req <= 1'b0;
      n = 0;
      while (ready_reg !== 1'b1 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      `CHK(n >= POR - 3 && n <= POR + 2, 1);
      `CHK(busy_reg, 1'b0);
    end
  endtask
  // idle detect; fast far start and stop seen
  task t_free;
    begin
      repeat (60) @(negedge clk);
      `CHK(bus_free_reg, 1'b1);
      fork i_smbt_far.do_start; join_none
      wait_for(0, 40);
      `CHK(n < 40, 1);
      `CHK(bus_free_reg, 1'b0);
      fork i_smbt_far.do_stop; join_none
      wait_for(1, 40);
      `CHK(n < 40, 1);
    end
  endtask
  // stretch budget runs out; next start clears it
  task t_text;
    begin
      fork
        begin
          i_smbt_far.do_start;
          i_smbt_far.hold_low(400);
        end
      join_none
      @(posedge clk);
      tgt_stretch <= 1'b1;
      wait_for(4, TEXT + 60);
      `CHK(n >= TEXT - 2 && n <= TEXT + 30, 1);
      @(posedge clk);
      tgt_stretch <= 1'b0;
      i_smbt_far.do_stop;
      repeat (20) @(negedge clk);
      fork i_smbt_far.do_start; join_none
      wait_for(0, 40);
      repeat (3) @(negedge clk);
      `CHK(text_viol_reg, 1'b0);
      i_smbt_far.do_stop;
    end
  endtask
  // own transfer: clock rate within class limits
  task t_ctrl;
    begin
      ctrl_start(1'b0);
      repeat (500) @(negedge clk);
      m = 0;
      p = 1'b0;
      for (k = 0; k < 2000; k = k + 1) begin
        @(negedge clk);
        if (clk_pin_oe === 1'b1 && !p) m = m + 1;
        p = clk_pin_oe;
      end
      `CHK(m >= 1 && m <= 11, 1);
      @(posedge clk);
      ack_mark <= 1'b1;
      @(posedge clk);
      ack_mark <= 1'b0;
      ctrl_stop;
    end
  endtask
  // far clock hold: timeout, stop, fresh start
  task t_to;
    begin
      ctrl_start(1'b1);
      repeat (500) @(negedge clk);
      fork i_smbt_far.hold_low(TMAX * 50 + 2000); join_none
      wait_for(2, TMIN + 400);
      `CHK(n <= TMIN + 10, 1);
      @(posedge clk);
      bit_req <= 1'b0;
      wait_for(1, 3000);
      `CHK(n < 3000, 1);
      wait_for(6, 400);
      `CHK(n < 400, 1);
      ctrl_start(1'b1);
      ctrl_stop;
    end
  endtask
  // forced timeout holds clock past maximum
  task t_force;
    begin
      @(posedge clk);
      force_timeout <= 1'b1;
      @(posedge clk);
      force_timeout <= 1'b0;
      m = 0;
      q = 1'b0;
      for (k = 0; k < 2 * TMAX; k = k + 1) begin
        @(negedge clk);
        if (clk_pin_oe === 1'b1) m = m + 1;
        if (timeout_reg === 1'b1) q = 1'b1;
      end
      `CHK(m >= TMAX, 1);
      `CHK(q, 1'b1);
    end
  endtask
  initial begin
    {start_req, stop_req, bit_req, bit_val, ack_mark, tgt_stretch, force_timeout} = 7'h00;
    rst = 1'b1;
    failures = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_por;
    t_free;
    t_text;
    t_ctrl;
    t_to;
    t_force;
    summarize;
  end
  // watchdog: about eight times the expected run
  initial begin
    #2000000;
    failures = failures + 1;
    summarize;
  end
endmodule // tb
